// file: rtl/sst_core.sv
// Synchronous transfer parameters and bus byte latches
// Functional notes
// - Disable-halt keeps target running until move ends
// - Period field value is period index
// - Core unit is clock times prescale divisor
// - Extra setup send period four plus index plus one
// - Otherwise send and receive four plus index
// - Sync prescale field overrides async divide
// - Offset zero async, one to eight sync
// - Offset applies to data phases only
// - Drive output latch only with assert-data bit
// - Phase mismatch blocks initiator data transfer
// - Every sent byte passes output latch
// - Control latch bits assert bus signals
// - Capture first byte of receiving move
// - Selection loads combined ID into capture
// - Input latch on asserting REQ or ACK
// - Driven output byte readable via input latch
// - Data view shows live data lines
// - Latch and view registers reset to zero
//
// Local design decision: strobed register access.
module sst_core
  import sst_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  input  wire logic            seq_ctl_wr,
  input  wire logic [7:0]      seq_ctl_data,
  input  wire logic            seq_send_wr,
  input  wire logic [7:0]      seq_send_data,
  input  wire logic            move_start,
  input  wire logic            move_receive,
  input  wire logic            move_done,
  input  wire logic            sel_event,
  input  wire logic [7:0]      sel_ids,
  input  wire logic            parity_err,
  input  wire logic [7:0]      bus_data_in,
  input  wire logic [7:0]      bus_ctl_in,
  output logic      [7:0]      bus_data_out,
  output logic                 bus_data_oe,
  output logic      [7:0]      bus_ctl_out,
  output logic                 halt_req,
  output logic                 phase_mismatch,
  output sst_xfer_s            xfer_active,
  output logic                 rx_byte_valid,
  output logic      [7:0]      rx_byte
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  xfer_ctrl_reg;
  logic [7:0]  out_data_reg;
  logic [7:0]  out_ctrl_reg;
  logic [7:0]  first_reg;
  logic [7:0]  in_data_reg;
  logic [7:0]  cfg_reg;
  logic [2:0]  data_s1_reg [8];
  logic [2:0]  ctl_s1_reg  [8];
  logic [7:0]  data_sync;
  logic [7:0]  ctl_sync;
  logic [7:0]  data_view_reg;
  logic [7:0]  ctl_view_reg;
  logic        req_prev_reg;
  logic        ack_prev_reg;
  logic        first_pend_reg;
  logic        move_busy_reg;
  logic        halt_pend_reg;
  logic [7:0]  rd_next;
  logic [5:0]  period_next;
  logic [3:0]  div_half;
  logic        strobe_edge;
  logic        target_mode;
  sst_ctl_s    ctl_live;
  sst_ctl_s    ctl_own;
  sst_phase_e  phase_live;
  logic        data_phase;
  logic        phase_bad;

  assign target_mode = cfg_reg[SST_CFG_TARGET];
  assign ctl_live    = sst_ctl_s'(ctl_view_reg);
  assign ctl_own     = sst_ctl_s'(out_ctrl_reg);
  assign phase_live  = sst_phase_e'({ctl_live.msg, ctl_live.cd, ctl_live.io});

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          data_s1_reg[gi] <= 3'h0;
          ctl_s1_reg[gi]  <= 3'h0;
        end
        else
        begin
          data_s1_reg[gi] <= {data_s1_reg[gi][1:0], bus_data_in[gi]};
          ctl_s1_reg[gi]  <= {ctl_s1_reg[gi][1:0], bus_ctl_in[gi]};
        end
      end
      assign data_sync[gi] = data_s1_reg[gi][2];
      assign ctl_sync[gi]  = ctl_s1_reg[gi][2];
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          data_view_reg[gi] <= 1'b0;
          ctl_view_reg[gi]  <= 1'b0;
        end
        else
        begin
          if (data_s1_reg[gi][1] == data_sync[gi])
            data_view_reg[gi] <= data_sync[gi];
          if (ctl_s1_reg[gi][1] == ctl_sync[gi])
            ctl_view_reg[gi] <= ctl_sync[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Handshake edge and phase check
  // ----------------------------------------
  // asserting REQ or ACK edge
  assign strobe_edge = target_mode ? (ctl_live.ack & ~ack_prev_reg) : (ctl_live.req & ~req_prev_reg);
  assign data_phase  = (phase_live == SST_PH_DOUT) || (phase_live == SST_PH_DIN);
  assign phase_bad   = ~target_mode & ({ctl_own.msg, ctl_own.cd, ctl_own.io} != phase_live);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_prev_reg   <= 1'b0;
      ack_prev_reg   <= 1'b0;
      phase_mismatch <= 1'b0;
    end
    else
    begin
      req_prev_reg   <= ctl_live.req;
      ack_prev_reg   <= ctl_live.ack;
      phase_mismatch <= ctl_live.req & phase_bad;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_ctrl_reg <= SST_REG_RESET;
      cfg_reg       <= SST_REG_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == SST_XFER_CTRL_OFS)
        xfer_ctrl_reg <= reg_wdata;
      if (reg_addr == SST_CFG_OFS)
        cfg_reg <= reg_wdata;
    end
  end

  // output latch carries every sent byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      out_data_reg <= SST_REG_RESET;
    else if (seq_send_wr)
      out_data_reg <= seq_send_data;
    else if (reg_wr && reg_addr == SST_OUT_DATA_OFS)
      out_data_reg <= reg_wdata;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      out_ctrl_reg <= SST_REG_RESET;
    else if (seq_ctl_wr)
      out_ctrl_reg <= seq_ctl_data;
    else if (reg_wr && reg_addr == SST_OUT_CTRL_OFS)
      out_ctrl_reg <= reg_wdata;
  end

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_data_out <= 8'h00;
      bus_data_oe  <= 1'b0;
      bus_ctl_out  <= 8'h00;
    end
    else
    begin
      bus_data_out <= out_data_reg;
      bus_data_oe  <= cfg_reg[SST_CFG_ADB] & ~(phase_mismatch & ~target_mode);
      bus_ctl_out  <= out_ctrl_reg;
    end
  end

  // ----------------------------------------
  // Receive latches
  // ----------------------------------------
  // latch data on strobe edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      in_data_reg   <= SST_REG_RESET;
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
    end
    else
    begin
      rx_byte_valid <= strobe_edge & ~phase_bad;
      if (strobe_edge)
      begin
        in_data_reg <= data_view_reg;
        rx_byte     <= data_view_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      first_reg      <= SST_REG_RESET;
      first_pend_reg <= 1'b0;
    end
    else if (sel_event)
    begin
      first_reg      <= sel_ids;
      first_pend_reg <= 1'b0;
    end
    else if (move_start && move_receive)
      first_pend_reg <= 1'b1;
    else if (first_pend_reg && strobe_edge && !phase_bad)
    begin
      first_reg      <= data_view_reg;
      first_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Halt control
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      move_busy_reg <= 1'b0;
      halt_pend_reg <= 1'b0;
      halt_req      <= 1'b0;
    end
    else
    begin
      if (move_start)
        move_busy_reg <= 1'b1;
      else if (move_done)
        move_busy_reg <= 1'b0;
      if (target_mode && (ctl_live.atn || parity_err) && xfer_ctrl_reg[SST_DHE_BIT])
        halt_pend_reg <= 1'b1;
      else if (move_done)
        halt_pend_reg <= 1'b0;
      if (!target_mode)
        halt_req <= 1'b0;
      else if (!xfer_ctrl_reg[SST_DHE_BIT])
        halt_req <= ctl_live.atn | parity_err;
      else
        halt_req <= (halt_pend_reg | ctl_live.atn | parity_err) & move_done & move_busy_reg;
    end
  end

  // ----------------------------------------
  // Period arithmetic
  // ----------------------------------------
  // async divide 00 two, 01 one and a half, 10 one
  always_comb
  begin
    div_half = 4'h4;
    unique case (cfg_reg[SST_CFG_PSC_LSB +: 2])
      2'b01: div_half = 4'h2;
      2'b10: div_half = 4'h3;
      2'b11: div_half = 4'h4;
      default:
      begin
        case (cfg_reg[SST_CFG_DIV_LSB +: 2])
          2'b00:   div_half = 4'h4;
          2'b01:   div_half = 4'h3;
          default: div_half = 4'h2;
        endcase
      end
    endcase
  end

  always_comb
  begin
    logic [3:0] units;
    units = SST_BASE_UNITS + {1'b0, xfer_ctrl_reg[SST_PER_LSB +: 3]};
    if (cfg_reg[SST_CFG_SETUP] && !move_receive)
      units = units + 4'h1;
    period_next = 6'(units * {2'b00, div_half});
  end

  // offset zero async, reserved values async
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      xfer_active <= '0;
    else if (move_start)
    begin
      xfer_active.offset            <= xfer_ctrl_reg[SST_OFS_LSB +: 4];
      xfer_active.sync_mode         <= data_phase && (xfer_ctrl_reg[SST_OFS_LSB +: 4] != 4'h0) &&
                                       (xfer_ctrl_reg[SST_OFS_LSB +: 4] <= SST_OFS_MAX);
      xfer_active.period_half_units <= period_next;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // registers read zero after reset
  always_comb
  begin
    rd_next = 8'h00;
    case (reg_addr)
      SST_XFER_CTRL_OFS: rd_next = xfer_ctrl_reg;
      SST_OUT_DATA_OFS:  rd_next = out_data_reg;
      SST_OUT_CTRL_OFS:  rd_next = out_ctrl_reg;
      SST_FIRST_OFS:     rd_next = first_reg;
      SST_IN_DATA_OFS:   rd_next = in_data_reg;
      SST_DATA_VIEW_OFS: rd_next = data_view_reg;
      SST_CFG_OFS:       rd_next = cfg_reg;
      SST_PERIOD_OFS:    rd_next = {2'b00, xfer_active.period_half_units};
      default:           rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end

endmodule

// file: rtl/sst_pkg.sv
// Package of constants and carriers for the synchronous transfer and latch block
package sst_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SST_XFER_CTRL_OFS = 8'h05;
  localparam logic [7:0] SST_OUT_DATA_OFS  = 8'h06;
  localparam logic [7:0] SST_OUT_CTRL_OFS  = 8'h07;
  localparam logic [7:0] SST_FIRST_OFS     = 8'h08;
  localparam logic [7:0] SST_IN_DATA_OFS   = 8'h09;
  localparam logic [7:0] SST_DATA_VIEW_OFS = 8'h0A;
  localparam logic [7:0] SST_CFG_OFS       = 8'h10;
  localparam logic [7:0] SST_PERIOD_OFS    = 8'h11;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         SST_DHE_BIT     = 7;
  localparam int         SST_PER_LSB     = 4;
  localparam int         SST_OFS_LSB     = 0;
  localparam logic [3:0] SST_OFS_MAX     = 4'h8;
  localparam int         SST_CFG_ADB     = 0;
  localparam int         SST_CFG_SETUP   = 1;
  localparam int         SST_CFG_DIV_LSB = 2;
  localparam int         SST_CFG_PSC_LSB = 4;
  localparam int         SST_CFG_TARGET  = 6;
  localparam logic [7:0] SST_REG_RESET   = 8'h00;
  localparam logic [3:0] SST_BASE_UNITS  = 4'h4;

  // ----------------------------------------
  // Bus phase and carriers
  // ----------------------------------------
  typedef enum logic [2:0] {
    SST_PH_DOUT = 3'b000,
    SST_PH_DIN  = 3'b001,
    SST_PH_CMD  = 3'b010,
    SST_PH_STAT = 3'b011,
    SST_PH_R4   = 3'b100,
    SST_PH_R5   = 3'b101,
    SST_PH_MOUT = 3'b110,
    SST_PH_MIN  = 3'b111
  } sst_phase_e;

  typedef struct packed {
    logic req;
    logic ack;
    logic bsy;
    logic sel;
    logic atn;
    logic msg;
    logic cd;
    logic io;
  } sst_ctl_s;

  typedef struct packed {
    logic       sync_mode;
    logic [3:0] offset;
    logic [5:0] period_half_units;
  } sst_xfer_s;

endpackage

// file: testbench/sst_core_assertions.sv
// Port checker for the transfer and latch block
module sst_core_assertions
  import sst_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       seq_ctl_wr,
  input wire logic       seq_send_wr,
  input wire logic       move_start,
  input wire logic [7:0] bus_data_out,
  input wire logic       bus_data_oe,
  input wire logic [7:0] bus_ctl_out,
  input wire logic       halt_req,
  input wire logic       phase_mismatch,
  input wire sst_xfer_s  xfer_active,
  input wire logic       rx_byte_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rst_quiet_a: assert property ($fell(rst) |-> !bus_data_oe && bus_ctl_out == 8'h00 && !halt_req)
    else $error("outputs active after reset");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  ctl_cause_a: assert property ($changed(bus_ctl_out) |-> $past(seq_ctl_wr || reg_wr) || $past(seq_ctl_wr || reg_wr, 2))
    else $error("control lines moved without a load");
  data_cause_a: assert property ($changed(bus_data_out) |-> $past(seq_send_wr || reg_wr) || $past(seq_send_wr || reg_wr, 2))
    else $error("data lines moved without a load");
  xfer_hold_a: assert property ($changed(xfer_active) |-> $past(move_start))
    else $error("transfer setting changed mid transfer");
  ofs_range_a: assert property (xfer_active.sync_mode |-> xfer_active.offset inside {[4'h1:4'h8]})
    else $error("sync offset out of range");
  per_range_a: assert property (xfer_active.sync_mode |-> xfer_active.period_half_units inside {[6'h08:6'h30]})
    else $error("sync period out of range");
  rx_pulse_a: assert property (rx_byte_valid |=> !rx_byte_valid)
    else $error("receive strobe longer than one cycle");
  rx_block_a: assert property (rx_byte_valid |-> !phase_mismatch)
    else $error("byte received during phase mismatch");
  rx_c: cover property (rx_byte_valid);
  sync_c: cover property (xfer_active.sync_mode);
  halt_c: cover property (halt_req);
endmodule

bind sst_core sst_core_assertions sst_core_assertions_i (.*);

// file: testbench/sst_bus_peer.sv
// Far-side bus device model: phase lines, handshake and data
module sst_bus_peer
  import sst_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [2:0] phase,
  input  wire logic       atn,
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_oe,
  input  wire logic [7:0] dev_ctl,
  output logic      [7:0] bus_data,
  output logic      [7:0] bus_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] own_data = 8'h00;
  logic       own_oe   = 1'b0;
  logic       own_req  = 1'b0;
  assign bus_ctl = dev_ctl | {own_req, 3'b010, atn, phase};
  // Released lines float to negated
  assign bus_data = (own_oe ? own_data : 8'h00) | (dev_oe ? dev_data : 8'h00);
  task automatic send(input logic [7:0] b, input logic drv, input int slow);
    own_data <= b;
    own_oe <= drv;
    repeat (1 + slow) @(posedge sys_clk);
    own_req <= 1'b1;
    repeat (5 + slow) @(posedge sys_clk);
    own_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    own_oe <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the transfer and latch block
module tb
  import sst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, seq_ctl_data, seq_send_data, sel_ids;
  logic [7:0]  bus_data_in, bus_ctl_in, bus_data_out, bus_ctl_out, rx_byte;
  logic        reg_wr, reg_rd, seq_ctl_wr, seq_send_wr, move_start, move_receive, move_done;
  logic        sel_event, parity_err, bus_data_oe, halt_req, phase_mismatch, rx_byte_valid;
  sst_xfer_s   xfer_active;
  logic [2:0]  phase;
  logic        atn, rx_watch, pm_seen;
  logic        rd_d = 1'b0;
  logic [7:0]  rdq[$], rxq[$];
  logic [31:0] lf = 32'hC5A4597F;
  int          num_errors, checks_done, cyc;
  logic [7:0]  ofs [7] = '{SST_XFER_CTRL_OFS, SST_OUT_DATA_OFS, SST_OUT_CTRL_OFS, SST_FIRST_OFS,
                           SST_IN_DATA_OFS, SST_DATA_VIEW_OFS, 8'h3F};

  sst_core sst_core_i (.*);
  sst_bus_peer sst_bus_peer_i (.sys_clk(sys_clk), .phase(phase), .atn(atn), .dev_data(bus_data_out),
    .dev_oe(bus_data_oe), .dev_ctl(bus_ctl_out), .bus_data(bus_data_in), .bus_ctl(bus_ctl_in));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rdq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_hi();
    for (int k = 0; k < 12 && halt_req !== 1'b1; k++) @(posedge sys_clk);
    chk("halt_req", 8'h01, {7'h00, halt_req});
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Output watcher and timeout
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", rdq.pop_front(), reg_rdata);
    if (phase_mismatch === 1'b1) pm_seen = 1'b1;
    if (rx_watch && rx_byte_valid === 1'b1) chk("rx_byte", rxq.size() > 0 ? rxq.pop_front() : ~rx_byte, rx_byte);
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    logic [7:0] b, f, x, c, e;
    logic [2:0] ph;
    logic       sy, rcv;
    {reg_addr, reg_wdata, seq_ctl_data, seq_send_data, sel_ids} = '0;
    {reg_wr, reg_rd, seq_ctl_wr, seq_send_wr, move_start, move_receive, move_done} = '0;
    {sel_event, parity_err, atn, rx_watch, pm_seen} = '0;
    phase = SST_PH_DOUT;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ofs[i]) rd(ofs[i], SST_REG_RESET);
    wr(SST_XFER_CTRL_OFS, 8'h85);
    wr(SST_FIRST_OFS, 8'hFF);
    rd(SST_XFER_CTRL_OFS, 8'h85);
    rd(SST_FIRST_OFS, 8'h00);
    wr(SST_OUT_DATA_OFS, 8'h5A);
    repeat (2) @(posedge sys_clk);
    chk("bus_data_oe", 8'h00, {7'h00, bus_data_oe});
    wr(SST_CFG_OFS, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("bus_data_out", 8'h5A, bus_data_out);
    chk("bus_data_oe", 8'h01, {7'h00, bus_data_oe});
    repeat (4) @(posedge sys_clk);
    rd(SST_DATA_VIEW_OFS, 8'h5A);
    sst_bus_peer_i.send(8'h00, 1'b0, 0);
    rd(SST_IN_DATA_OFS, 8'h5A);
    reg_addr <= SST_OUT_DATA_OFS;
    reg_wdata <= 8'h11;
    reg_wr <= 1'b1;
    seq_send_data <= 8'hC3;
    seq_send_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    seq_send_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("bus_data_out", 8'hC3, bus_data_out);
    rd(SST_OUT_DATA_OFS, 8'hC3);
    wr(SST_CFG_OFS, 8'h00);
    wr(SST_OUT_CTRL_OFS, 8'h01);
    phase <= SST_PH_DIN;
    move_receive <= 1'b1;
    move_start <= 1'b1;
    @(posedge sys_clk);
    move_start <= 1'b0;
    rx_watch = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      b = lf[7:0];
      lf = nxt(lf);
      if (i == 0) f = b;
      rxq.push_back(b);
      sst_bus_peer_i.send(b, 1'b1, i);
    end
    rd(SST_FIRST_OFS, f);
    rd(SST_IN_DATA_OFS, b);
    phase <= SST_PH_STAT;
    repeat (6) @(posedge sys_clk);
    sst_bus_peer_i.send(8'h77, 1'b1, 1);
    chk("phase_mismatch", 8'h01, {7'h00, pm_seen});
    chk("rx_pending", 8'h00, 8'(rxq.size()));
    rx_watch = 1'b0;
    sel_ids <= 8'h81;
    sel_event <= 1'b1;
    @(posedge sys_clk);
    sel_event <= 1'b0;
    @(posedge sys_clk);
    rd(SST_FIRST_OFS, 8'h81);
    for (int i = 0; i < 4; i++)
    begin
      b = lf[7:0];
      lf = nxt(lf);
      wr(SST_OUT_CTRL_OFS, b);
      repeat (2) @(posedge sys_clk);
      chk("bus_ctl_out", b, bus_ctl_out);
      rd(SST_OUT_CTRL_OFS, b);
    end
    seq_ctl_data <= 8'h00;
    seq_ctl_wr <= 1'b1;
    @(posedge sys_clk);
    seq_ctl_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("bus_ctl_out", 8'h00, bus_ctl_out);
    for (int i = 0; i < 16; i++)
    begin
      x = lf[7:0];
      c = {2'b00, lf[9:8], (lf[11:10] == 2'b11) ? 2'b10 : lf[11:10], lf[12], 1'b0};
      ph = lf[16] ? {2'b00, lf[17]} : SST_PH_CMD;
      rcv = lf[18];
      lf = nxt(lf);
      wr(SST_XFER_CTRL_OFS, x);
      wr(SST_CFG_OFS, c);
      wr(SST_OUT_CTRL_OFS, {5'h00, ph});
      phase <= ph;
      repeat (6) @(posedge sys_clk);
      move_receive <= rcv;
      move_start <= 1'b1;
      @(posedge sys_clk);
      move_start <= 1'b0;
      @(posedge sys_clk);
      sy = x[3:0] inside {[4'h1:4'h8]} && ph[2:1] == 2'b00;
      e = (4'h4 + x[6:4] + (c[1] & ~rcv)) * (c[5:4] == 2'b00 ? 4'h4 - c[3:2] : c[5:4] + 4'h1);
      chk("sync_mode", {7'h00, sy}, {7'h00, xfer_active.sync_mode});
      if (sy)
      begin
        chk("offset", {4'h0, x[3:0]}, {4'h0, xfer_active.offset});
        chk("period", e, {2'b00, xfer_active.period_half_units});
      end
      rd(SST_CFG_OFS, c);
      rd(SST_PERIOD_OFS, e);
    end
    wr(SST_CFG_OFS, 8'h40);
    wr(SST_XFER_CTRL_OFS, 8'h00);
    atn <= 1'b1;
    wait_hi();
    atn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(SST_XFER_CTRL_OFS, 8'h80);
    move_start <= 1'b1;
    parity_err <= 1'b1;
    @(posedge sys_clk);
    move_start <= 1'b0;
    parity_err <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("halt_req", 8'h00, {7'h00, halt_req});
    move_done <= 1'b1;
    @(posedge sys_clk);
    move_done <= 1'b0;
    wait_hi();
    conclude();
  end
endmodule
